// *** design/ofrc_pkg.sv ***
// constants, command codes and helpers for the output fault response block
package ofrc_pkg;

	localparam int CLK_PERIOD_NS = 100;

	// command codes
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_OUT_MODE = 8'h20;
	localparam logic [7:0] CMD_OV_ACTION = 8'h41;
	localparam logic [7:0] CMD_UV_LIMIT = 8'h44;
	localparam logic [7:0] CMD_UV_ACTION = 8'h45;
	localparam logic [7:0] CMD_OC_LIMIT = 8'h46;

	// values after reset
	localparam logic [7:0] ACTION_RESET = 8'h80;
	localparam logic [15:0] OC_LIMIT_RESET = 16'he250;
	localparam logic [15:0] OUT_MODE_VALUE = 16'h0013;

	// action byte fields
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int TIME_HI = 2;
	localparam int TIME_LO = 0;
	localparam logic [1:0] MODE_IGNORE = 2'h0;
	localparam logic [1:0] MODE_DELAY = 2'h1;
	localparam logic [1:0] MODE_SHUT = 2'h2;
	localparam logic [1:0] MODE_HOLD = 2'h3;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// undervoltage power-up limit is 17/20 of the strapped target
	localparam int UV_NUM = 17;
	localparam int UV_DEN = 20;

	// current in 1/16 A steps
	localparam int Q4_SHIFT = 4;
	localparam int OC_MAX_Q4 = 1600;
	localparam int OC_MIN_Q4 = -1600;

	// time units per count and sense blanking
	localparam int OV_UNIT_NS = 1000;
	localparam int UV_UNIT_NS = 10000;
	localparam int BLANK_NS = 200;
	localparam int OV_UNIT_CYCLES = (OV_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UV_UNIT_CYCLES = (UV_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLANK_CYCLES = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// eleven-bit mantissa linear value to signed 1/16 A
	function automatic logic signed [31:0] ofrc_l11_to_q4(input logic [15:0] v);
		logic signed [31:0] m;
		logic signed [5:0] e;
		m = 32'(signed'(v[10:0]));
		e = 6'(signed'(v[15:11])) + 6'sd4;
		if (e[5])
			ofrc_l11_to_q4 = m >>> 6'(-e);
		else
			ofrc_l11_to_q4 = m <<< e;
	endfunction

endpackage

// *** design/ofrc_rsp_if.sv ***
// link between the top and one fault responder
interface ofrc_rsp_if;
	logic ce;
	logic en;
	logic fault;
	logic other_stop;
	logic [7:0] cfg;
	logic off;
	logic trip;
	modport ctrl (output ce, en, fault, other_stop, cfg, input off, trip);
	modport resp (input ce, en, fault, other_stop, cfg, output off, trip);
endinterface

// *** design/ofrc_oc_filter.sv ***
// blanking window and consecutive-sample qualifier for peak overcurrent
module ofrc_oc_filter
	import ofrc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	// samples
	input wire logic cycle_start_i,
	input wire logic sample_valid_i,
	input wire logic over_i,
	input wire logic [3:0] run_len_i,
	// result
	output logic fault_o
);
	localparam logic [7:0] BLANK_LOAD = 8'(BLANK_CYCLES);

	logic [7:0] blank_q;
	logic [3:0] run_q;
	logic qual;
	logic [3:0] need;

	assign qual = sample_valid_i && !cycle_start_i && (blank_q == 8'h00);
	assign need = (run_len_i == 4'h0) ? 4'h1 : run_len_i;

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			blank_q <= 8'h00;
		else if (ce_i)
		begin
			if (cycle_start_i)
				blank_q <= BLANK_LOAD;
			else if (blank_q != 8'h00)
				blank_q <= blank_q - 8'h01;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			run_q <= 4'h0;
			fault_o <= 1'b0;
		end
		else if (ce_i && qual)
		begin
			if (over_i)
			begin
				if (run_q != 4'hf)
					run_q <= run_q + 4'h1;
				if ((5'(run_q) + 5'h01) >= 5'(need))
					fault_o <= 1'b1;
			end
			else
			begin
				run_q <= 4'h0;
				fault_o <= 1'b0;
			end
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_oc_qualified: assert property ($rose(fault_o) |-> $past(qual && over_i && ce_i))
		else $error("overcurrent declared without a qualified sample");
	a_blank_ignored: assert property ((blank_q != 8'h00) && !fault_o |=> !fault_o)
		else $error("overcurrent declared inside blanking");
endmodule

// *** design/ofrc_responder.sv ***
// response state machine for one fault: delay, shut, retry or hold off
module ofrc_responder
	import ofrc_pkg::*;
#(
	parameter int UNIT_CYCLES = 10
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// control link
	ofrc_rsp_if.resp rsp
);
	typedef enum logic [2:0] {st_run, st_delay, st_wait, st_latched, st_hold} ofrc_state_t;

	localparam logic [11:0] UNIT_LAST = 12'(UNIT_CYCLES - 1);

	ofrc_state_t state_q;
	logic [11:0] unit_q;
	logic [2:0] tcnt_q;
	logic [2:0] attempts_q;
	logic off_prev_q;
	logic tick;
	logic [1:0] mode;
	logic [2:0] retry;
	logic [2:0] ttime;
	logic may_retry;

	assign mode = rsp.cfg[MODE_HI:MODE_LO];
	assign retry = rsp.cfg[RETRY_HI:RETRY_LO];
	assign ttime = rsp.cfg[TIME_HI:TIME_LO];
	assign tick = (unit_q == 12'h000);
	assign may_retry = (retry == RETRY_FOREVER) || ((retry != RETRY_NONE) && (attempts_q != 3'h0));
	assign rsp.off = (state_q == st_wait) || (state_q == st_latched) || (state_q == st_hold);
	assign rsp.trip = rsp.off && !off_prev_q;

	// time base for the delay and retry counts
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			unit_q <= UNIT_LAST;
		else if (rsp.ce)
			unit_q <= tick ? UNIT_LAST : unit_q - 12'h001;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			off_prev_q <= 1'b0;
		else if (rsp.ce)
			off_prev_q <= rsp.off;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			state_q <= st_run;
			tcnt_q <= 3'h0;
			attempts_q <= RETRY_NONE;
		end
		else if (rsp.ce)
		begin
			if (!rsp.en)
			begin
				state_q <= st_run;
				attempts_q <= retry;
			end
			else
			begin
				unique case (state_q)
					st_run:
						if (rsp.fault)
						begin
							if (mode == MODE_DELAY)
							begin
								state_q <= st_delay;
								tcnt_q <= ttime;
							end
							else if (mode == MODE_HOLD)
								state_q <= st_hold;
							else if (mode == MODE_SHUT)
							begin
								state_q <= may_retry ? st_wait : st_latched;
								tcnt_q <= ttime;
								if (retry != RETRY_FOREVER && may_retry)
									attempts_q <= attempts_q - 3'h1;
							end
						end
					st_delay:
						if (!rsp.fault)
							state_q <= st_run;
						else if (tick)
						begin
							if (tcnt_q == 3'h0)
							begin
								state_q <= may_retry ? st_wait : st_latched;
								tcnt_q <= ttime;
								if (retry != RETRY_FOREVER && may_retry)
									attempts_q <= attempts_q - 3'h1;
							end
							else
								tcnt_q <= tcnt_q - 3'h1;
						end
					st_wait:
						if (rsp.other_stop && retry == RETRY_FOREVER)
							state_q <= st_latched;
						else if (tick)
						begin
							if (tcnt_q == 3'h0)
								state_q <= st_run;
							else
								tcnt_q <= tcnt_q - 3'h1;
						end
					st_latched:
						state_q <= st_latched;
					st_hold:
						if (!rsp.fault)
							state_q <= st_run;
				endcase
			end
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_shut_at_once: assert property (rsp.ce && rsp.en && state_q == st_run && rsp.fault
		&& mode == MODE_SHUT |=> rsp.off)
		else $error("immediate shutdown did not switch the output off");
	a_delay_first: assert property (rsp.ce && rsp.en && state_q == st_run && rsp.fault
		&& mode == MODE_DELAY |=> !rsp.off && state_q == st_delay)
		else $error("delayed response switched off without delay");
	a_hold_release: assert property (rsp.ce && rsp.en && state_q == st_hold && !rsp.fault
		|=> !rsp.off)
		else $error("hold-off did not release after the fault cleared");
	a_no_retry_wait: assert property (state_q == st_wait |-> retry != RETRY_NONE)
		else $error("retry wait entered with retries off");
	a_attempt_bound: assert property (state_q == st_wait && retry != RETRY_FOREVER
		&& $stable(rsp.cfg) |-> attempts_q < retry)
		else $error("restart attempts exceed the retry field");
	a_forever_stop: assert property (rsp.ce && rsp.en && state_q == st_wait
		&& retry == RETRY_FOREVER && rsp.other_stop |=> state_q == st_latched)
		else $error("continuous retry not stopped by another shutdown");
	a_delay_count: assert property (state_q == st_delay && $stable(rsp.cfg) |-> tcnt_q <= ttime)
		else $error("delay count above the time field");
	a_reload_count: assert property (rsp.ce && !rsp.en |=> attempts_q == $past(retry))
		else $error("attempt counter not reloaded on disable");
	c_retry_cycle: cover property (state_q == st_wait ##[1:200] state_q == st_run);
endmodule

// *** design/ofrc_top.sv ***
// output overvoltage, undervoltage and overcurrent fault settings and responses
// Summary of operation
// - overvoltage action never stores the ignore code
// - ignore code keeps regulating through the fault
// - delay code waits time count, then shuts
// - shut code turns output off at once
// - hold code keeps output off while fault persists
// - fault flags stay set until clear faults
// - retry zero latches the output off
// - retry one to six limits restart attempts
// - retry seven restarts until disable or a shutdown by the other responder
// - time field sets delay and retry spacing
// - action bytes reset to disable, no retry
// - undervoltage masked while ramping or disabled
// - undervoltage limit starts at 0.85 strap, clamped
// - overcurrent uses peak samples after blanking
// - overcurrent needs consecutive samples above limit
// - overcurrent limit resets to 37 A, bounded
// - output mode read reports exponent minus thirteen
module ofrc_top
	import ofrc_pkg::*;
(
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	// command port from the management link decoder
	input wire logic cmd_wr_i,
	input wire logic cmd_rd_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [15:0] cmd_data_i,
	output logic [15:0] rd_data_o,
	output logic rd_valid_o,
	output logic rd_hit_o,
	// straps and voltage bounds
	input wire logic [15:0] vout_strap_i,
	input wire logic [15:0] vout_max_i,
	// measurements
	input wire logic [15:0] vout_meas_i,
	input wire logic ov_detect_i,
	input wire logic ramping_i,
	input wire logic pwm_cycle_start_i,
	input wire logic isense_valid_i,
	input wire logic signed [15:0] isense_q4_i,
	input wire logic [3:0] maker_specific_configuration_run_len_i,
	// enable pin
	input wire logic enable_pin_i,
	// output control and status
	output logic output_on_o,
	output logic ov_flag_o,
	output logic uv_flag_o,
	output logic oc_flag_o,
	output logic oc_fault_o
);
	localparam int N_RSP = 2;
	localparam int IDX_OV = 0;
	localparam int IDX_UV = 1;

	logic [7:0] action_q [N_RSP];
	logic [15:0] uv_limit_q;
	logic [15:0] oc_limit_q;
	logic init_done_q;
	logic en_meta_q;
	logic en_sync_q;
	logic output_on_q;
	logic ov_flag_q;
	logic uv_flag_q;
	logic oc_flag_q;
	logic [15:0] rd_data_q;
	logic rd_valid_q;
	logic rd_hit_q;
	logic fault_w [N_RSP];
	logic off_w [N_RSP];
	logic trip_w [N_RSP];
	logic uv_detect;
	logic oc_over;
	logic oc_fault;
	logic clear_faults;
	logic signed [31:0] oc_limit_q4;
	logic signed [31:0] wr_q4;

	// commands this block answers
	function automatic logic ofrc_known(input logic [7:0] code);
		ofrc_known = (code == CMD_OUT_MODE) || (code == CMD_OV_ACTION)
			|| (code == CMD_UV_LIMIT) || (code == CMD_UV_ACTION) || (code == CMD_OC_LIMIT);
	endfunction

	assign clear_faults = ce_i && cmd_wr_i && (cmd_code_i == CMD_CLEAR_FAULTS);
	assign oc_limit_q4 = ofrc_l11_to_q4(oc_limit_q);
	assign wr_q4 = ofrc_l11_to_q4(cmd_data_i);
	assign uv_detect = output_on_q && !ramping_i && (vout_meas_i < uv_limit_q);
	assign oc_over = 32'(isense_q4_i) > oc_limit_q4;
	assign fault_w[IDX_OV] = ov_detect_i;
	assign fault_w[IDX_UV] = uv_detect;

	// enable pin synchroniser
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			en_meta_q <= 1'b0;
			en_sync_q <= 1'b0;
		end
		else if (ce_i)
		begin
			en_meta_q <= enable_pin_i;
			en_sync_q <= en_meta_q;
		end
	end

	// response action bytes
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			action_q[IDX_OV] <= ACTION_RESET;
			action_q[IDX_UV] <= ACTION_RESET;
		end
		else if (ce_i && cmd_wr_i)
		begin
			if (cmd_code_i == CMD_OV_ACTION)
			begin
				if (cmd_data_i[MODE_HI:MODE_LO] == MODE_IGNORE)
					action_q[IDX_OV] <= {MODE_SHUT, cmd_data_i[RETRY_HI:TIME_LO]};
				else
					action_q[IDX_OV] <= cmd_data_i[7:0];
			end
			if (cmd_code_i == CMD_UV_ACTION)
				action_q[IDX_UV] <= cmd_data_i[7:0];
		end
	end

	// undervoltage limit: strap-derived after reset, clamped on write
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			uv_limit_q <= 16'h0000;
			init_done_q <= 1'b0;
		end
		else if (ce_i)
		begin
			if (!init_done_q)
			begin
				uv_limit_q <= 16'((32'(vout_strap_i) * UV_NUM) / UV_DEN);
				init_done_q <= 1'b1;
			end
			else if (cmd_wr_i && cmd_code_i == CMD_UV_LIMIT)
			begin
				if (cmd_data_i > vout_max_i)
					uv_limit_q <= vout_max_i;
				else
					uv_limit_q <= cmd_data_i;
			end
		end
	end

	// overcurrent limit: out-of-range writes are refused
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			oc_limit_q <= OC_LIMIT_RESET;
		else if (ce_i && cmd_wr_i && cmd_code_i == CMD_OC_LIMIT)
		begin
			if (wr_q4 <= OC_MAX_Q4 && wr_q4 >= OC_MIN_Q4)
				oc_limit_q <= cmd_data_i;
		end
	end

	// registered read answer
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			rd_data_q <= 16'h0000;
			rd_valid_q <= 1'b0;
			rd_hit_q <= 1'b0;
		end
		else if (ce_i)
		begin
			rd_valid_q <= cmd_rd_i;
			if (cmd_rd_i)
			begin
				rd_hit_q <= ofrc_known(cmd_code_i);
				unique case (cmd_code_i)
					CMD_OUT_MODE:
						rd_data_q <= OUT_MODE_VALUE;
					CMD_OV_ACTION:
						rd_data_q <= {8'h00, action_q[IDX_OV]};
					CMD_UV_ACTION:
						rd_data_q <= {8'h00, action_q[IDX_UV]};
					CMD_UV_LIMIT:
						rd_data_q <= uv_limit_q;
					CMD_OC_LIMIT:
						rd_data_q <= oc_limit_q;
					default:
						rd_data_q <= 16'h0000;
				endcase
			end
		end
	end

	// sticky fault flags; a new detection wins over clear
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			ov_flag_q <= 1'b0;
			uv_flag_q <= 1'b0;
			oc_flag_q <= 1'b0;
		end
		else if (ce_i)
		begin
			ov_flag_q <= ov_detect_i || (ov_flag_q && !clear_faults);
			uv_flag_q <= uv_detect || (uv_flag_q && !clear_faults);
			oc_flag_q <= oc_fault || (oc_flag_q && !clear_faults);
		end
	end

	// output follows the synchronised enable after init, unless a responder holds it off; ignore leaves it on
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			output_on_q <= 1'b0;
		else if (ce_i)
			output_on_q <= en_sync_q && init_done_q && !off_w[IDX_OV] && !off_w[IDX_UV];
	end

	ofrc_rsp_if rsp [N_RSP] ();

	for (genvar g = 0; g < N_RSP; g++)
	begin : g_rsp
		assign rsp[g].ce = ce_i;
		assign rsp[g].en = en_sync_q;
		assign rsp[g].fault = fault_w[g];
		assign rsp[g].cfg = action_q[g];
		assign rsp[g].other_stop = trip_w[N_RSP - 1 - g];
		assign off_w[g] = rsp[g].off;
		assign trip_w[g] = rsp[g].trip;

		ofrc_responder #(
			.UNIT_CYCLES((g == IDX_OV) ? OV_UNIT_CYCLES : UV_UNIT_CYCLES)
		) u_responder (
			.clk_i(clk_i),
			.reset_n_i(reset_n_i),
			.rsp(rsp[g])
		);
	end

	ofrc_oc_filter u_oc_filter (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.cycle_start_i(pwm_cycle_start_i),
		.sample_valid_i(isense_valid_i),
		.over_i(oc_over),
		.run_len_i(maker_specific_configuration_run_len_i),
		.fault_o(oc_fault)
	);

	assign rd_data_o = rd_data_q;
	assign rd_valid_o = rd_valid_q;
	assign rd_hit_o = rd_hit_q;
	assign output_on_o = output_on_q;
	assign ov_flag_o = ov_flag_q;
	assign uv_flag_o = uv_flag_q;
	assign oc_flag_o = oc_flag_q;
	assign oc_fault_o = oc_fault;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_ov_never_ignore: assert property (action_q[IDX_OV][MODE_HI:MODE_LO] != MODE_IGNORE)
		else $error("overvoltage action holds the ignore code");
	a_ignore_no_off: assert property (action_q[IDX_UV][MODE_HI:MODE_LO] == MODE_IGNORE
		&& $stable(action_q[IDX_UV]) && !off_w[IDX_UV] |=> !off_w[IDX_UV])
		else $error("ignore code switched the output off");
	a_flag_sticky: assert property (ov_flag_q && !clear_faults |=> ov_flag_q)
		else $error("fault flag dropped without clear");
	a_set_beats_clear: assert property (ce_i && oc_fault && clear_faults |=> oc_flag_q)
		else $error("clear lost a simultaneous fault");
	a_reset_action: assert property (!$past(reset_n_i) |-> action_q[IDX_OV] == ACTION_RESET
		&& action_q[IDX_UV] == ACTION_RESET && oc_limit_q == OC_LIMIT_RESET)
		else $error("wrong values after reset");
	a_uv_masked: assert property ((ramping_i || !output_on_q) && ce_i && !uv_flag_q
		&& !clear_faults |=> !uv_flag_q)
		else $error("undervoltage flagged while masked");
	a_uv_clamp: assert property (ce_i && init_done_q && cmd_wr_i && cmd_code_i == CMD_UV_LIMIT
		&& cmd_data_i > vout_max_i |=> uv_limit_q == $past(vout_max_i))
		else $error("undervoltage limit above output maximum");
	a_oc_range: assert property (oc_limit_q4 <= OC_MAX_Q4 && oc_limit_q4 >= OC_MIN_Q4)
		else $error("overcurrent limit out of range");
	a_mode_read: assert property (ce_i && cmd_rd_i && cmd_code_i == CMD_OUT_MODE
		|=> rd_valid_o && rd_hit_o && rd_data_o == OUT_MODE_VALUE)
		else $error("output mode read wrong");
	c_ov_trip: cover property (output_on_q ##1 ov_detect_i ##[1:5] !output_on_q);
	c_uv_flag: cover property ($rose(uv_flag_q));
	c_oc_flag: cover property ($rose(oc_flag_q));
	c_clear: cover property (ov_flag_q ##1 clear_faults ##1 !ov_flag_q);
endmodule

// *** verif/ofrc_host_model.sv ***
// management host model: issues register writes and reads on the command port
module ofrc_host_model
	import ofrc_pkg::*;
(
	// clock
	input wire logic clk_i,
	// command port
	output logic cmd_wr_o,
	output logic cmd_rd_o,
	output logic [7:0] cmd_code_o,
	output logic [15:0] cmd_data_o,
	// read answer
	input wire logic [15:0] rd_data_i,
	input wire logic rd_valid_i,
	input wire logic rd_hit_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hung = 1'b0;

	initial
	begin
		cmd_wr_o = 1'b0;
		cmd_rd_o = 1'b0;
		cmd_code_o = 8'h00;
		cmd_data_o = 16'h0000;
	end

	// one-cycle write strobe; an edge passes first so strobes never merge
	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		@(posedge clk_i);
		cmd_code_o <= code;
		cmd_data_o <= data;
		cmd_wr_o <= 1'b1;
		@(posedge clk_i);
		cmd_wr_o <= 1'b0;
	endtask

	// one-cycle read strobe, then a bounded wait for the answer
	task automatic rd(input logic [7:0] code, output logic [15:0] d, output logic h);
		@(posedge clk_i);
		cmd_code_o <= code;
		cmd_rd_o <= 1'b1;
		@(posedge clk_i);
		cmd_rd_o <= 1'b0;
		d = 'x;
		h = 1'bx;
		for (int i = 0; i < 4; i++)
		begin
			#1;
			if (rd_valid_i === 1'b1)
			begin
				d = rd_data_i;
				h = rd_hit_i;
				return;
			end
			@(posedge clk_i);
		end
		hung = 1'b1;
	endtask
endmodule

// *** verif/tb_ofrc_top.sv ***
// self-checking bench for the output fault response block
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_ofrc_top
	import ofrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_wr, cmd_rd, rd_valid, rd_hit;
	logic [7:0] cmd_code;
	logic [15:0] cmd_data, rd_data;
	logic [15:0] strap = 16'h2000;
	logic [15:0] vmax = 16'h2333;
	logic [15:0] vmeas = 16'h2000;
	logic ov = 1'b0;
	logic ramp = 1'b0;
	logic pstart = 1'b0;
	logic ivalid = 1'b0;
	logic signed [15:0] isense = 16'sd0;
	logic [3:0] run_len = 4'h3;
	logic en_pin = 1'b1;
	logic out_on, ov_flag, uv_flag, oc_flag, oc_fault;
	int err_total = 0;
	int n_compared = 0;
	int cnt;
	logic [7:0] rcode [6] = '{8'h41, 8'h45, 8'h46, 8'h20, 8'h44, 8'h50};
	logic [15:0] rval [6] = '{16'h0080, 16'h0080, 16'he250, 16'h0013, 16'h1b33, 16'h0000};
	logic [7:0] wcode [7] = '{8'h41, 8'h45, 8'h46, 8'h46, 8'h46, 8'h44, 8'h44};
	logic [15:0] wdat [7] = '{16'h000d, 16'h0000, 16'h0032, 16'h0865, 16'he250, 16'hffff,
		16'h1b33};
	logic [15:0] wexp [7] = '{16'h008d, 16'h0000, 16'h0032, 16'h0032, 16'he250, 16'h2333,
		16'h1b33};
	logic [2:0] rtry [3] = '{3'h2, 3'h7, 3'h2};

	always #50 clk = ~clk;

	ofrc_host_model u_host (.clk_i(clk), .cmd_wr_o(cmd_wr), .cmd_rd_o(cmd_rd),
		.cmd_code_o(cmd_code), .cmd_data_o(cmd_data), .rd_data_i(rd_data),
		.rd_valid_i(rd_valid), .rd_hit_i(rd_hit));

	ofrc_top DUT (.clk_i(clk), .reset_n_i(rst_n), .ce_i(1'b1), .cmd_wr_i(cmd_wr),
		.cmd_rd_i(cmd_rd), .cmd_code_i(cmd_code), .cmd_data_i(cmd_data),
		.rd_data_o(rd_data), .rd_valid_o(rd_valid), .rd_hit_o(rd_hit),
		.vout_strap_i(strap), .vout_max_i(vmax), .vout_meas_i(vmeas), .ov_detect_i(ov),
		.ramping_i(ramp), .pwm_cycle_start_i(pstart), .isense_valid_i(ivalid),
		.isense_q4_i(isense), .maker_specific_configuration_run_len_i(run_len),
		.enable_pin_i(en_pin), .output_on_o(out_on), .ov_flag_o(ov_flag),
		.uv_flag_o(uv_flag), .oc_flag_o(oc_flag), .oc_fault_o(oc_fault));

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic rchk(input logic [7:0] code, input logic [15:0] exp, input logic hit);
		logic [15:0] d;
		logic h;
		u_host.rd(code, d, h);
		`CHK(d, exp)
		`CHK(h, hit)
	endtask

	// toggling the enable pin clears a latched-off output
	task automatic restart_out();
		en_pin <= 1'b0;
		cyc(5);
		en_pin <= 1'b1;
		cyc(6);
	endtask

	task automatic count_rises(input int n, output int r);
		logic p;
		p = out_on;
		r = 0;
		repeat (n)
		begin
			@(posedge clk);
			#1;
			if (out_on === 1'b1 && p === 1'b0)
				r++;
			p = out_on;
		end
	endtask

	task automatic give_verdict();
		$display("counts: %0d compared, %0d wrong", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clk)
		if (u_host.hung === 1'b1)
		begin
			err_total++;
			give_verdict();
		end

	initial
	begin
		cyc(6);
		rst_n <= 1'b1;
		cyc(6);
		#1;
		`CHK(out_on, 1'b1)
		foreach (rcode[i])
			rchk(rcode[i], rval[i], rcode[i] != 8'h50);
		$display("done: reset values");
		foreach (wcode[i])
		begin
			u_host.wr(wcode[i], wdat[i]);
			rchk(wcode[i], wexp[i], 1'b1);
		end
		$display("done: register writes");
		u_host.wr(CMD_OV_ACTION, 16'h0080);
		@(posedge clk);
		ov <= 1'b1;
		@(posedge clk);
		#1;
		`CHK(ov_flag, 1'b1)
		`CHK(out_on, 1'b1)
		@(posedge clk);
		#1;
		`CHK(out_on, 1'b0)
		ov <= 1'b0;
		cyc(50);
		#1;
		`CHK(out_on, 1'b0)
		`CHK(ov_flag, 1'b1)
		u_host.wr(CMD_CLEAR_FAULTS, 16'h0000);
		#1;
		`CHK(ov_flag, 1'b0)
		restart_out();
		#1;
		`CHK(out_on, 1'b1)
		$display("done: shutdown without retry");
		u_host.wr(CMD_OV_ACTION, 16'h00c0);
		ov <= 1'b1;
		cyc(5);
		#1;
		`CHK(out_on, 1'b0)
		ov <= 1'b0;
		cyc(5);
		#1;
		`CHK(out_on, 1'b1)
		$display("done: hold while faulted");
		u_host.wr(CMD_OV_ACTION, 16'h0042);
		ov <= 1'b1;
		cyc(15);
		#1;
		`CHK(out_on, 1'b1)
		cyc(20);
		#1;
		`CHK(out_on, 1'b0)
		ov <= 1'b0;
		restart_out();
		$display("done: delayed shutdown");
		foreach (rtry[i])
		begin
			u_host.wr(CMD_OV_ACTION, 16'h0080 | (16'(rtry[i]) << 3));
			// the attempt counter takes the new retry field while the enable is low
			restart_out();
			ov <= 1'b1;
			count_rises(300, cnt);
			`CHK((rtry[i] == 3'h2) ? (cnt == 2) : (cnt > 6), 1'b1)
			ov <= 1'b0;
			restart_out();
		end
		$display("done: restart attempts");
		vmeas <= 16'h1000;
		cyc(4);
		#1;
		`CHK(uv_flag, 1'b1)
		`CHK(out_on, 1'b1)
		vmeas <= 16'h2000;
		u_host.wr(CMD_CLEAR_FAULTS, 16'h0000);
		ramp <= 1'b1;
		vmeas <= 16'h1000;
		cyc(5);
		#1;
		`CHK(uv_flag, 1'b0)
		ramp <= 1'b0;
		vmeas <= 16'h2000;
		$display("done: undervoltage ignore and mask");
		@(posedge clk);
		pstart <= 1'b1;
		ivalid <= 1'b1;
		isense <= 16'sd600;
		@(posedge clk);
		pstart <= 1'b0;
		cyc(4);
		#1;
		`CHK(oc_fault, 1'b0)
		@(posedge clk);
		#1;
		`CHK(oc_fault, 1'b1)
		pstart <= 1'b1;
		isense <= 16'sd0;
		@(posedge clk);
		pstart <= 1'b0;
		cyc(2);
		#1;
		`CHK(oc_flag, 1'b1)
		`CHK(oc_fault, 1'b1)
		@(posedge clk);
		#1;
		`CHK(oc_fault, 1'b0)
		ivalid <= 1'b0;
		$display("done: overcurrent qualify");
		give_verdict();
	end
endmodule
